/* File: hdl/sacs_regs.vh */
// constants of the conversion sequencer
`ifndef SACS_REGS_VH
`define SACS_REGS_VH

`define SACS_MODE_NOCAL_BIT   3
`define SACS_MODE_NOPD_BIT    2
`define SACS_MODE_RES_MSB     1
`define SACS_MODE_RES_LSB     0

`define SACS_RES_10BIT        2'h0
`define SACS_RES_12BIT        2'h1
`define SACS_RES_8BIT         2'h2
`define SACS_RES_UNUSED       2'h3

`define SACS_BITS_8           4'h8
`define SACS_BITS_10          4'ha
`define SACS_BITS_12          4'hc

`define SACS_SAMPLE_BASE      9'h002
`define SACS_POSTCAL_TICKS    9'h002
`define SACS_DIV_FACTOR_LOG2  2
`define SACS_CAL_TICKS        3840

`define SACS_ST_IDLE          3'h0
`define SACS_ST_SAMPLE        3'h1
`define SACS_ST_DISTRIB       3'h2
`define SACS_ST_POSTCAL       3'h3

`endif

/* File: hdl/sacs_clkdiv.v */
// conversion clock divider: period of 4 x (1 + divide value) system clocks
`timescale 1ns/10ps
`include "sacs_regs.vh"

module sacs_clkdiv #(
    parameter DIV_W = 8
) (
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire             restart,
    input  wire [DIV_W-1:0] divide_value,
    output wire             tick,
    output reg              clk_q
);
    localparam CW = DIV_W + `SACS_DIV_FACTOR_LOG2;

    reg  [CW-1:0] cnt_q;
    wire [CW-1:0] last_w;

    assign last_w = {divide_value, {`SACS_DIV_FACTOR_LOG2{1'b1}}};
    assign tick   = (cnt_q == last_w) & ~restart;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= {CW{1'b0}};
            clk_q <= 1'b0;
        end else if (restart || cnt_q >= last_w) begin
            // a divide value lowered mid-period wraps at once
            cnt_q <= {CW{1'b0}};
            clk_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            clk_q <= (cnt_q < {1'b0, last_w[CW-1:1]});
        end
    end
endmodule // sacs_clkdiv

/* File: hdl/sacs_sar.v */
// successive-approximation register, one bit decided per step
`timescale 1ns/10ps

module sacs_sar #(
    parameter W = 12
) (
    input  wire         sys_clk,
    input  wire         sys_rst,
    input  wire         load,
    input  wire         step,
    input  wire [3:0]   nbits,
    input  wire         cmp_above,
    output reg  [W-1:0] code_q,
    output reg  [W-1:0] code_next
);
    reg [W-1:0] mask_q;
    reg [W-1:0] mask_d;
    reg [W-1:0] kept;

    always @* begin
        kept      = cmp_above ? code_q : (code_q & ~mask_q);
        mask_d    = mask_q >> 1;
        code_next = code_q;
        if (load) begin
            mask_d    = {{(W-1){1'b0}}, 1'b1} << (nbits - 4'h1);
            code_next = mask_d;
        end else if (step) begin
            code_next = kept | mask_d;
        end else begin
            mask_d = mask_q;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            code_q <= {W{1'b0}};
            mask_q <= {W{1'b0}};
        end else begin
            code_q <= code_next;
            mask_q <= mask_d;
        end
    end
endmodule // sacs_sar

/* File: hdl/sacs_seq.v */
// conversion sequencer: sample, distribution, optional post-calibration
//
// What this block does
// - post-calibration adds exactly two conversion clocks after distribution, else none
// - busy stays high through the whole post-calibration phase
// - without post-calibration busy falls right at distribution end
// - result-valid rises with busy falling, result already on outputs
// - result-valid holds high until the next conversion start
// - mode bit 3 decides whether post-calibration runs
// - conversion time is start sync, sample, distribution and post-cal
// - a start during power-up calibration is taken and carried out
// - a start mid-conversion drops it and begins anew two edges later, after the start sync
// - restarts never change the 3840-cycle power-up calibration
// - conversion clock period is 4 x (1 + divide value) system clocks
// - distribution lasts one conversion clock per resolution bit
// - power-down after conversion does not slow conversions
// - mode bit 3 low enables post-calibration, high skips it
// - sample phase start raises busy and the sampling flag
// - distribution start drops sampling while busy stays high
// - sample phase lasts 2 plus sample-time value conversion clocks
`timescale 1ns/10ps
`include "sacs_regs.vh"

module sacs_seq #(
    parameter DIV_W     = 8,
    parameter STC_W     = 8,
    parameter RES_W     = 12,
    parameter TIME_W    = 20,
    parameter CAL_TICKS = `SACS_CAL_TICKS
) (
    input  wire              sys_clk,
    input  wire              sys_rst,
    input  wire              conversion_start,
    input  wire [DIV_W-1:0]  clock_divide_value,
    input  wire [STC_W-1:0]  sample_time_value,
    input  wire [3:0]        mode,
    input  wire              comparator_above,
    output reg               busy_q,
    output reg               sample_q,
    output reg               result_valid_q,
    output reg  [RES_W-1:0]  result_q,
    output reg               calibrating_q,
    output reg               power_down_q,
    output reg  [TIME_W-1:0] conv_cycles_q,
    output wire [RES_W-1:0]  trial_code_q,
    output wire              conversion_clock
);
    reg  [2:0]        state_q;
    reg               start_q;
    reg  [STC_W:0]    left_q;
    reg  [3:0]        mode_q;
    reg  [DIV_W-1:0]  div_q;
    reg  [3:0]        nbits_q;
    reg  [TIME_W-1:0] run_cnt_q;
    reg  [11:0]       cal_cnt_q;
    reg  [3:0]        nbits_d;

    localparam [11:0] CAL_LAST = CAL_TICKS - 1;

    wire              tick;
    wire              cal_tick;
    wire              sar_load;
    wire              sar_step;
    wire              last_tick;
    wire              post_on;
    wire [RES_W-1:0]  code_q;
    wire [RES_W-1:0]  code_next;

    // resolution from mode bits 1:0; the unused code falls back to 10 bits
    always @* begin
        case (mode[`SACS_MODE_RES_MSB:`SACS_MODE_RES_LSB])
            `SACS_RES_12BIT: nbits_d = `SACS_BITS_12;
            `SACS_RES_8BIT:  nbits_d = `SACS_BITS_8;
            default:         nbits_d = `SACS_BITS_10;
        endcase
    end

    assign post_on   = ~mode_q[`SACS_MODE_NOCAL_BIT];
    assign last_tick = tick & (left_q == {(STC_W+1){1'b0}});
    assign sar_load  = (state_q == `SACS_ST_SAMPLE) & last_tick & ~start_q;
    assign sar_step  = (state_q == `SACS_ST_DISTRIB) & tick & ~start_q;
    assign trial_code_q = code_q;

    sacs_clkdiv #(
        .DIV_W        (DIV_W)
    ) u_conv_div (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .restart      (start_q),
        .divide_value (div_q),
        .tick         (tick),
        .clk_q        (conversion_clock)
    );

    sacs_clkdiv #(
        .DIV_W        (DIV_W)
    ) u_cal_div (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .restart      (1'b0),
        .divide_value (clock_divide_value),
        .tick         (cal_tick),
        .clk_q        ()
    );

    sacs_sar #(
        .W            (RES_W)
    ) u_sar (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .load         (sar_load),
        .step         (sar_step),
        .nbits        (nbits_q),
        .cmp_above    (comparator_above),
        .code_q       (code_q),
        .code_next    (code_next)
    );

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= conversion_start;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cal_cnt_q     <= 12'h000;
            calibrating_q <= 1'b1;
        end else if (calibrating_q && cal_tick) begin
            cal_cnt_q <= cal_cnt_q + 12'h001;
            if (cal_cnt_q == CAL_LAST) begin
                calibrating_q <= 1'b0;
            end
        end
    end

    // settings are latched at start so mid-conversion changes do no harm
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_q  <= 4'h0;
            div_q   <= {DIV_W{1'b0}};
            nbits_q <= `SACS_BITS_10;
        end else if (start_q) begin
            mode_q  <= mode;
            div_q   <= clock_divide_value;
            nbits_q <= nbits_d;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            run_cnt_q     <= {TIME_W{1'b0}};
            conv_cycles_q <= {TIME_W{1'b0}};
        end else if (start_q) begin
            run_cnt_q <= {{(TIME_W-2){1'b0}}, 2'h2};
        end else begin
            if (busy_q) begin
                run_cnt_q <= run_cnt_q + {{(TIME_W-1){1'b0}}, 1'b1};
            end
            // busy and state fall together, so capture once valid stands
            if (result_valid_q) begin
                conv_cycles_q <= run_cnt_q;
            end
        end
    end

    // main phase sequencer
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q        <= `SACS_ST_IDLE;
            left_q         <= {(STC_W+1){1'b0}};
            busy_q         <= 1'b0;
            sample_q       <= 1'b0;
            result_valid_q <= 1'b0;
            result_q       <= {RES_W{1'b0}};
        end else if (start_q) begin
            state_q        <= `SACS_ST_SAMPLE;
            left_q         <= {1'b0, sample_time_value} + `SACS_SAMPLE_BASE - 9'h001;
            busy_q         <= 1'b1;
            sample_q       <= 1'b1;
            result_valid_q <= 1'b0;
        end else begin
            case (state_q)
                `SACS_ST_SAMPLE: begin
                    if (last_tick) begin
                        state_q  <= `SACS_ST_DISTRIB;
                        sample_q <= 1'b0;
                        left_q   <= {{(STC_W-3){1'b0}}, nbits_q} - 9'h001;
                    end else if (tick) begin
                        left_q <= left_q - 9'h001;
                    end
                end
                `SACS_ST_DISTRIB: begin
                    if (last_tick) begin
                        if (post_on) begin
                            state_q <= `SACS_ST_POSTCAL;
                            left_q  <= `SACS_POSTCAL_TICKS - 9'h001;
                        end else begin
                            state_q        <= `SACS_ST_IDLE;
                            busy_q         <= 1'b0;
                            result_valid_q <= 1'b1;
                            result_q       <= code_next;
                        end
                    end else if (tick) begin
                        left_q <= left_q - 9'h001;
                    end
                end
                `SACS_ST_POSTCAL: begin
                    if (last_tick) begin
                        state_q        <= `SACS_ST_IDLE;
                        busy_q         <= 1'b0;
                        result_valid_q <= 1'b1;
                        result_q       <= code_q;
                    end else if (tick) begin
                        left_q <= left_q - 9'h001;
                    end
                end
                default: begin
                    state_q <= `SACS_ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            power_down_q <= 1'b0;
        end else begin
            power_down_q <= ~busy_q & ~start_q & ~conversion_start
                            & ~mode_q[`SACS_MODE_NOPD_BIT] & result_valid_q;
        end
    end
endmodule // sacs_seq

/* File: test/sacs_seq_checker.sv */
// timing checker for the conversion sequencer ports
`timescale 1ns/10ps

module sacs_seq_checker #(
    parameter DIV_W = 8,
    parameter STC_W = 8,
    parameter RES_W = 12
) (
    input wire logic             sys_clk,
    input wire logic             sys_rst,
    input wire logic             conversion_start,
    input wire logic [DIV_W-1:0] clock_divide_value,
    input wire logic [STC_W-1:0] sample_time_value,
    input wire logic [3:0]       mode,
    input wire logic             busy_q,
    input wire logic             sample_q,
    input wire logic             result_valid_q,
    input wire logic [RES_W-1:0] result_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // settings latched like the design, counts since start and since sampling
    int p_q, k_q, n_q, pc_q, scnt_q, dcnt_q;
    always @(posedge sys_clk) begin
        if (conversion_start) begin
            p_q    <= 4 * (1 + clock_divide_value);
            k_q    <= 2 + sample_time_value;
            n_q    <= (mode[1:0] == 2'h1) ? 12 : ((mode[1:0] == 2'h2) ? 8 : 10);
            pc_q   <= mode[3] ? 0 : 2;
            scnt_q <= 0;
        end else begin
            scnt_q <= scnt_q + 1;
        end
        dcnt_q <= sample_q ? 0 : dcnt_q + 1;
    end

    property p_start; conversion_start |-> ##2 busy_q && sample_q && !result_valid_q; endproperty
    a_start: assert property (p_start) else $error("no sample phase after start");
    property p_drop; $fell(sample_q) |-> busy_q; endproperty
    a_drop: assert property (p_drop) else $error("busy low at sampling end");
    property p_valid; $fell(busy_q) |-> result_valid_q; endproperty
    a_valid: assert property (p_valid) else $error("valid missing at busy fall");
    property p_vhold;
        result_valid_q && !conversion_start && !$past(conversion_start) |=> result_valid_q;
    endproperty
    a_vhold: assert property (p_vhold) else $error("valid dropped without start");
    property p_slen; $fell(sample_q) |-> scnt_q == 1 + k_q * p_q; endproperty
    a_slen: assert property (p_slen) else $error("sample phase length wrong");
    property p_post; $fell(busy_q) |-> dcnt_q == (n_q + pc_q) * p_q; endproperty
    a_post: assert property (p_post) else $error("distribution or post-cal length wrong");
    property p_total; $rose(result_valid_q) |-> scnt_q == 1 + (k_q + n_q + pc_q) * p_q; endproperty
    a_total: assert property (p_total) else $error("conversion time wrong");
    property p_res; result_valid_q && $past(result_valid_q) |-> $stable(result_q); endproperty
    a_res: assert property (p_res) else $error("result moved while valid");
    property p_inj; conversion_start && busy_q && !sample_q |-> ##1 busy_q ##1 sample_q; endproperty
    a_inj: assert property (p_inj) else $error("injected start not restarted");

    c_inj: cover property (conversion_start && busy_q && !sample_q);
    c_post: cover property ($rose(result_valid_q) && pc_q == 2);
    c_nopost: cover property ($rose(result_valid_q) && pc_q == 0);
endmodule // sacs_seq_checker

bind sacs_seq sacs_seq_checker #(.DIV_W(DIV_W), .STC_W(STC_W), .RES_W(RES_W)) chk_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .conversion_start(conversion_start),
    .clock_divide_value(clock_divide_value), .sample_time_value(sample_time_value),
    .mode(mode), .busy_q(busy_q), .sample_q(sample_q), .result_valid_q(result_valid_q),
    .result_q(result_q));

/* File: test/sacs_far_model.sv */
// far-side model: analog input level seen through the comparator
`timescale 1ns/10ps

module sacs_far_model (
    input  wire logic [11:0] level,
    input  wire logic [11:0] trial_code_q,
    output wire logic        comparator_above
);
    // ideal comparator, no offset, so the code must equal the level
    assign comparator_above = (level >= trial_code_q);
endmodule // sacs_far_model

/* File: test/testbench.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps

module testbench;
    logic        sys_clk, sys_rst, conversion_start, comparator_above;
    logic        busy_q, sample_q, result_valid_q, calibrating_q, power_down_q, conversion_clock;
    logic [7:0]  clock_divide_value, sample_time_value;
    logic [3:0]  mode;
    logic [11:0] result_q, trial_code_q, level;
    logic [19:0] conv_cycles_q;
    logic [31:0] r;
    integer      err_count, samples_checked, seed, i;

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    // short calibration keeps the run brief
    sacs_seq #(.CAL_TICKS(4)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .conversion_start(conversion_start), .clock_divide_value(clock_divide_value),
        .sample_time_value(sample_time_value), .mode(mode), .comparator_above(comparator_above),
        .busy_q(busy_q), .sample_q(sample_q), .result_valid_q(result_valid_q),
        .result_q(result_q), .calibrating_q(calibrating_q), .power_down_q(power_down_q),
        .conv_cycles_q(conv_cycles_q), .trial_code_q(trial_code_q),
        .conversion_clock(conversion_clock));
    sacs_far_model far_u (.level(level), .trial_code_q(trial_code_q),
        .comparator_above(comparator_above));

    function integer nbits(input [3:0] md);
        nbits = (md[1:0] == 2'h1) ? 12 : ((md[1:0] == 2'h2) ? 8 : 10);
    endfunction

    function integer exp_cycles(input [7:0] dv, input [7:0] st, input [3:0] md);
        exp_cycles = 2 + (2 + st + nbits(md) + (md[3] ? 0 : 2)) * 4 * (1 + dv);
    endfunction

    task test_done;
        begin
            $display("checks %0d errors %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("unexpected %s: expected %0h seen %0h", what, e, g);
            end
        end
    endtask

    // one conversion; inj first starts a run that is dropped mid-distribution
    task run_conv(input [7:0] dv, input [7:0] st, input [3:0] md, input inj);
        integer t;
        begin
            if (inj) begin
                @(negedge sys_clk);
                clock_divide_value = 8'h00;
                sample_time_value = 8'h00;
                mode = ~md;
                conversion_start = 1'b1;
                @(negedge sys_clk);
                conversion_start = 1'b0;
                // second start well past the two-clock minimum spacing
                repeat (10) @(negedge sys_clk);
            end
            @(negedge sys_clk);
            clock_divide_value = dv;
            sample_time_value = st;
            mode = md;
            level = $random(seed);
            level = level & ~(12'hfff << nbits(md));
            conversion_start = 1'b1;
            @(negedge sys_clk);
            conversion_start = 1'b0;
            @(negedge sys_clk);
            t = 2;
            check("valid cleared", 32'h0, result_valid_q);
            while (result_valid_q !== 1'b1 && t < 20000) begin
                @(negedge sys_clk);
                t = t + 1;
            end
            if (t >= 20000) begin
                err_count = err_count + 1;
                test_done();
            end
            check("conversion time", exp_cycles(dv, st, md), t);
            check("result", level, result_q);
            check("busy", 32'h0, busy_q);
            // at least one clock after valid before the next start
            @(negedge sys_clk);
            check("valid held", 32'h1, result_valid_q);
            check("cycle count", exp_cycles(dv, st, md), conv_cycles_q);
            check("power down", {31'h0, ~md[2]}, power_down_q);
        end
    endtask

    initial begin
        seed = 32'h73fcf2c9;
        err_count = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        conversion_start = 1'b0;
        clock_divide_value = 8'h00;
        sample_time_value = 8'h00;
        mode = 4'h0;
        level = 12'h000;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        check("calibrating", 32'h1, calibrating_q);
        run_conv(8'h00, 8'h00, 4'h4, 1'b0);
        for (i = 0; i < 16; i = i + 1) begin
            run_conv(8'h00, 8'h01, i[3:0], i[0]);
        end
        run_conv(8'hff, 8'h00, 4'ha, 1'b0);
        run_conv(8'h00, 8'hff, 4'h1, 1'b1);
        for (i = 0; i < 30; i = i + 1) begin
            r = $random(seed);
            run_conv({6'h00, r[1:0]}, {4'h0, r[5:2]}, r[9:6], r[10]);
        end
        check("calibration done", 32'h0, calibrating_q);
        test_done();
    end
endmodule // testbench
